// [inc/timer_pair_map.svh]
// register addresses, field positions and reset values of the timer pair
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH
`define TIMER_A_COUNT_ADDR   16'hFF50
`define TIMER_A_MATCH_ADDR   16'hFF51
`define TIMER_A_CONTROL_ADDR 16'hFF53
`define TIMER_B_COUNT_ADDR   16'hFF54
`define TIMER_B_MATCH_ADDR   16'hFF55
`define TIMER_B_CONTROL_ADDR 16'hFF57
`define CONTROL_RESET        8'h00
`define COUNT_RESET          8'h00
`define TIMER_A_CONTROL_MASK 8'h82
`define TIMER_B_CONTROL_MASK 8'h87
`define RUN_BIT              7
`define TIMER_A_PICK_BIT     1
`define TIMER_B_PICK_HI_BIT  2
`define TIMER_B_PICK_LO_BIT  1
`define TIMER_B_OUT_BIT      0
`define PRESCALE_WIDTH       9
`define TIMER_A_FAST_LOG     4'h6
`define TIMER_A_SLOW_LOG     4'h9
`define TIMER_B_FAST_LOG     4'h4
`define TIMER_B_SLOW_LOG     4'h8
`endif

// [inc/timer_pair_pkg.sv]
// types shared by the timer pair
package timer_pair_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic        wr_en;
      logic [7:0]  wr_data;
      logic        rd_en;
   } cpu_access_type;
   typedef enum logic [1:0] {
      src_div_fast = 2'h0,
      src_div_slow = 2'h1,
      src_rise     = 2'h2,
      src_fall     = 2'h3
   } b_source_type;
endpackage

// [hdl/timer_pair.sv]
// two 8-bit timers with compare match, event counting and square wave
`timescale 1ns/10ps
`default_nettype none
`include "timer_pair_map.svh"
module timer_pair
(
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   input  wire timer_pair_pkg::cpu_access_type cpu,
   input  wire logic                          event_input_pin,
   output logic [7:0]                         rd_data_q,
   output logic                               timer_a_match_irq,
   output logic                               timer_b_match_irq,
   output logic                               square_wave_pin,
   output logic                               square_wave_pin_oe
);
   logic [`PRESCALE_WIDTH-1:0] pre_q;
   logic [`PRESCALE_WIDTH-1:0] pre_d;
   logic [7:0]                 timer_a_control_q;
   logic [7:0]                 timer_a_control_d;
   logic [7:0]                 timer_b_control_q;
   logic [7:0]                 timer_b_control_d;
   logic [7:0]                 count_q [2];
   logic [7:0]                 count_d [2];
   logic [7:0]                 match_q [2];
   logic [7:0]                 match_d [2];
   logic [1:0]                 irq_q;
   logic [1:0]                 irq_d;
   logic [1:0]                 run;
   logic [1:0]                 tick;
   logic [1:0]                 hit;
   logic                       wave_q;
   logic                       wave_d;
   logic                       ev_prev_q;
   logic [7:0]                 rd_d;
   logic                       timer_a_run;
   logic                       timer_a_clock_pick;
   logic                       timer_b_run;
   logic                       timer_b_output_on;
   timer_pair_pkg::b_source_type b_src;

   function automatic logic sel(input logic [15:0] a, input logic [15:0] r);
      sel = (a == r);
   endfunction

   function automatic logic pre_tick(input logic [`PRESCALE_WIDTH-1:0] p,
                                     input logic [3:0] lg);
      logic [`PRESCALE_WIDTH-1:0] mask;
      mask = (`PRESCALE_WIDTH'(1) << lg) - `PRESCALE_WIDTH'(1);
      pre_tick = ((p & mask) == mask);
   endfunction

   assign timer_a_run        = timer_a_control_q[`RUN_BIT];
   assign timer_a_clock_pick = timer_a_control_q[`TIMER_A_PICK_BIT];
   assign timer_b_run        = timer_b_control_q[`RUN_BIT];
   assign timer_b_output_on  = timer_b_control_q[`TIMER_B_OUT_BIT];
   assign b_src = timer_pair_pkg::b_source_type'(
      {timer_b_control_q[`TIMER_B_PICK_HI_BIT],
       timer_b_control_q[`TIMER_B_PICK_LO_BIT]});
   assign run = {timer_b_run, timer_a_run};

   // count sources; prescaler runs free so both timers share phase
   always_comb
   begin
      pre_d = pre_q + `PRESCALE_WIDTH'(1);
      tick[0] = timer_a_clock_pick ?
                pre_tick(pre_q, `TIMER_A_SLOW_LOG) :
                pre_tick(pre_q, `TIMER_A_FAST_LOG);
      case (b_src)
         timer_pair_pkg::src_div_fast:
            tick[1] = pre_tick(pre_q, `TIMER_B_FAST_LOG);
         timer_pair_pkg::src_div_slow:
            tick[1] = pre_tick(pre_q, `TIMER_B_SLOW_LOG);
         timer_pair_pkg::src_rise:
            tick[1] = event_input_pin & ~ev_prev_q;
         timer_pair_pkg::src_fall:
            tick[1] = ~event_input_pin & ev_prev_q;
         default:
            tick[1] = 1'b0;
      endcase
   end

   // control and match registers written by the cpu
   always_comb
   begin
      timer_a_control_d = timer_a_control_q;
      timer_b_control_d = timer_b_control_q;
      match_d[0] = match_q[0];
      match_d[1] = match_q[1];
      if (cpu.wr_en)
      begin
         if (sel(cpu.addr, `TIMER_A_CONTROL_ADDR))
            timer_a_control_d = cpu.wr_data & `TIMER_A_CONTROL_MASK;
         if (sel(cpu.addr, `TIMER_B_CONTROL_ADDR))
            timer_b_control_d = cpu.wr_data & `TIMER_B_CONTROL_MASK;
         if (sel(cpu.addr, `TIMER_A_MATCH_ADDR))
            match_d[0] = cpu.wr_data;
         if (sel(cpu.addr, `TIMER_B_MATCH_ADDR))
            match_d[1] = cpu.wr_data;
      end
   end

   // counters; match clears in the same tick so period is match plus one
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_timer
         always_comb
         begin
            hit[i] = run[i] & tick[i] & (count_q[i] == match_q[i]);
            irq_d[i] = hit[i];
            if (!run[i])
               count_d[i] = `COUNT_RESET;
            else if (hit[i])
               count_d[i] = `COUNT_RESET;
            else if (tick[i])
               count_d[i] = count_q[i] + 8'h01;
            else
               count_d[i] = count_q[i];
         end
      end
   endgenerate

   // only timer b owns a pin; wave level drops when it stops
   always_comb
   begin
      if (!timer_b_run)
         wave_d = 1'b0;
      else if (hit[1] && timer_b_output_on)
         wave_d = ~wave_q;
      else
         wave_d = wave_q;
   end

   always_comb
   begin
      rd_d = 8'h00;
      if (cpu.rd_en)
      begin
         if (sel(cpu.addr, `TIMER_A_COUNT_ADDR))
            rd_d = count_q[0];
         else if (sel(cpu.addr, `TIMER_B_COUNT_ADDR))
            rd_d = count_q[1];
         else if (sel(cpu.addr, `TIMER_A_CONTROL_ADDR))
            rd_d = timer_a_control_q;
         else if (sel(cpu.addr, `TIMER_B_CONTROL_ADDR))
            rd_d = timer_b_control_q;
         else
            rd_d = 8'h00;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pre_q              <= '0;
         timer_a_control_q  <= `CONTROL_RESET;
         timer_b_control_q  <= `CONTROL_RESET;
         count_q[0]         <= `COUNT_RESET;
         count_q[1]         <= `COUNT_RESET;
         irq_q              <= 2'h0;
         wave_q             <= 1'b0;
         ev_prev_q          <= 1'b0;
         rd_data_q          <= 8'h00;
         square_wave_pin_oe <= 1'b0;
      end
      else
      begin
         pre_q              <= pre_d;
         timer_a_control_q  <= timer_a_control_d;
         timer_b_control_q  <= timer_b_control_d;
         count_q[0]         <= count_d[0];
         count_q[1]         <= count_d[1];
         irq_q              <= irq_d;
         wave_q             <= wave_d;
         ev_prev_q          <= event_input_pin;
         rd_data_q          <= rd_d;
         square_wave_pin_oe <= timer_b_control_d[`TIMER_B_OUT_BIT];
      end
   end

   // no reset on purpose: match value is undefined until written
   always_ff @(posedge sys_clk)
   begin
      match_q[0] <= match_d[0];
      match_q[1] <= match_d[1];
   end

   assign timer_a_match_irq = irq_q[0];
   assign timer_b_match_irq = irq_q[1];
   assign square_wave_pin   = wave_q;

   AST_IRQ_ON_MATCH: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      run[0] && tick[0] && count_q[0] == match_q[0] |=> timer_a_match_irq)
      else $error("timer a match without irq");
   AST_READ_COUNT: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      cpu.rd_en && cpu.addr == `TIMER_B_COUNT_ADDR
      |=> rd_data_q == $past(count_q[1]))
      else $error("timer b count read wrong");
   AST_CTRL_RESET: assert property (@(posedge sys_clk)
      !rst_n |=> timer_a_control_q == 8'h00 && timer_b_control_q == 8'h00)
      else $error("control not cleared by reset");
   AST_A_STOP_CLEAR: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      !timer_a_run |=> count_q[0] == 8'h00)
      else $error("stopped timer a not cleared");
   AST_B_STOP_CLEAR: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      !timer_b_run[*2] |-> count_q[1] == 8'h00 && !timer_b_match_irq)
      else $error("stopped timer b not cleared");
   AST_A_SLOW_TICK: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      tick[0] && timer_a_clock_pick |-> pre_q[8:0] == 9'h1FF)
      else $error("slow tick off the 512 boundary");
   AST_STEP: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      run[0] && tick[0] && !hit[0] |=> count_q[0] == $past(count_q[0]) + 8'h01)
      else $error("timer a did not step");
   AST_WRAP: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      hit[1] |=> count_q[1] == 8'h00 && timer_b_match_irq)
      else $error("timer b did not wrap on match");
   AST_TOGGLE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      hit[1] && timer_b_output_on
      |=> square_wave_pin != $past(square_wave_pin))
      else $error("wave did not invert on match");
   AST_WAVE_LOW: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      !timer_b_run |=> !square_wave_pin)
      else $error("wave not forced low when stopped");
   AST_EDGE_COUNT: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      timer_b_run && b_src == timer_pair_pkg::src_rise && event_input_pin
      && !ev_prev_q && !hit[1] |=> count_q[1] == $past(count_q[1]) + 8'h01)
      else $error("rising edge not counted");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the timer pair against a cycle model
`timescale 1ns/10ps
`default_nettype none
`include "timer_pair_map.svh"
module testbench;
   logic                           sys_clk;
   logic                           rst_n;
   timer_pair_pkg::cpu_access_type cpu;
   logic                           event_input_pin;
   logic [7:0]                     rd_data_q;
   logic                           timer_a_match_irq;
   logic                           timer_b_match_irq;
   logic                           square_wave_pin;
   logic                           square_wave_pin_oe;
   int                             fail_count = 0;
   int                             n_checks = 0;
   int                             cyc = 0;
   logic [8:0]                     m_presc;
   logic [7:0]                     m_ca, m_cb, m_ma, m_mb, m_rd;
   logic [7:0]                     m_cnt_a, m_cnt_b;
   logic                           m_irq_a, m_irq_b, m_wave, m_prev;
   logic                           ta, tb, eb;
   logic [15:0]                    addrs [8] = '{16'hFF50, 16'hFF51,
      16'hFF52, 16'hFF53, 16'hFF54, 16'hFF55, 16'hFF56, 16'hFF57};

   timer_pair timer_pair_inst
   (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .cpu                (cpu),
      .event_input_pin    (event_input_pin),
      .rd_data_q          (rd_data_q),
      .timer_a_match_irq  (timer_a_match_irq),
      .timer_b_match_irq  (timer_b_match_irq),
      .square_wave_pin    (square_wave_pin),
      .square_wave_pin_oe (square_wave_pin_oe)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic test_done();
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_bit(input string nm, input logic e, input logic g);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic acc(input logic [15:0] a, input logic w,
                      input logic [7:0] d, input logic r);
      cpu = '{addr: a, wr_en: w, wr_data: d, rd_en: r};
      @(negedge sys_clk);
   endtask

   task automatic idle(input int n);
      cpu = '0;
      repeat (n) @(negedge sys_clk);
   endtask

   // match and clock pick only change while stopped, as software must
   task automatic run(input logic sel, input logic [7:0] ctl,
                      input logic [7:0] m, input int div);
      logic [15:0] b;
      int          n;
      b = sel ? `TIMER_B_COUNT_ADDR : `TIMER_A_COUNT_ADDR;
      n = (2 * (int'(m) + 1) * div + 40) / 16;
      acc(b + 16'h0003, 1'b1, 8'h00, 1'b0);
      acc(b + 16'h0001, 1'b1, m, 1'b0);
      acc(b + 16'h0003, 1'b1, ctl & 8'h7F, 1'b0);
      acc(b + 16'h0003, 1'b1, ctl, 1'b0);
      repeat (n)
      begin
         acc(b, 1'b0, 8'h00, 1'b1);
         idle(15);
      end
      acc(b + 16'h0003, 1'b1, 8'h00, 1'b0);
      acc(b, 1'b0, 8'h00, 1'b1);
      idle(3);
   endtask

   // model: ticks and compares use the control value before the edge
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (!rst_n)
      begin
         {m_presc, m_ca, m_cb, m_cnt_a, m_cnt_b, m_rd} = '0;
         {m_irq_a, m_irq_b, m_wave, m_prev} = '0;
      end
      else
      begin
         ta = m_ca[7] && (m_ca[1] ? &m_presc : &m_presc[5:0]);
         case (m_cb[2:1])
            2'h0: eb = &m_presc[3:0];
            2'h1: eb = &m_presc[7:0];
            2'h2: eb = event_input_pin & ~m_prev;
            default: eb = ~event_input_pin & m_prev;
         endcase
         tb = m_cb[7] && eb;
         m_rd = 8'h00;
         if (cpu.rd_en)
            case (cpu.addr)
               `TIMER_A_COUNT_ADDR: m_rd = m_cnt_a;
               `TIMER_B_COUNT_ADDR: m_rd = m_cnt_b;
               `TIMER_A_CONTROL_ADDR: m_rd = m_ca;
               `TIMER_B_CONTROL_ADDR: m_rd = m_cb;
               default: m_rd = 8'h00;
            endcase
         m_irq_a = ta && (m_cnt_a == m_ma);
         m_irq_b = tb && (m_cnt_b == m_mb);
         if (m_irq_b && m_cb[0])
            m_wave = ~m_wave;
         if (!m_cb[7])
            m_wave = 1'b0;
         m_cnt_a = (!m_ca[7] || m_irq_a) ? 8'h00 : m_cnt_a + {7'h00, ta};
         m_cnt_b = (!m_cb[7] || m_irq_b) ? 8'h00 : m_cnt_b + {7'h00, tb};
         if (cpu.wr_en)
            case (cpu.addr)
               `TIMER_A_CONTROL_ADDR: m_ca = cpu.wr_data & 8'h82;
               `TIMER_B_CONTROL_ADDR: m_cb = cpu.wr_data & 8'h87;
               `TIMER_A_MATCH_ADDR: m_ma = cpu.wr_data;
               `TIMER_B_MATCH_ADDR: m_mb = cpu.wr_data;
               default: m_rd = m_rd;
            endcase
         m_presc = m_presc + 9'h001;
         m_prev = event_input_pin;
      end
      if (cyc == 40000)
      begin
         fail_count = fail_count + 1;
         test_done();
      end
   end

   always @(negedge sys_clk)
   begin
      if (cyc > 10)
         event_input_pin <= 1'($urandom);
      if (cyc > 1)
      begin
         check_bit("irq_a", m_irq_a, timer_a_match_irq);
         check_bit("irq_b", m_irq_b, timer_b_match_irq);
         check_bit("wave", m_wave, square_wave_pin);
         check_bit("oe", m_cb[0], square_wave_pin_oe);
         check("rd_data", m_rd, rd_data_q);
      end
   end

   initial
   begin
      void'($urandom(32'hF6E9));
      rst_n = 1'b0;
      cpu = '0;
      event_input_pin = 1'b0;
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      foreach (addrs[i])
         acc(addrs[i], 1'b0, 8'h00, 1'b1);
      acc(16'hFF52, 1'b1, 8'hFF, 1'b0);
      acc(`TIMER_A_CONTROL_ADDR, 1'b1, 8'h7F, 1'b0);
      acc(`TIMER_B_CONTROL_ADDR, 1'b1, 8'h7F, 1'b0);
      acc(`TIMER_A_CONTROL_ADDR, 1'b0, 8'h00, 1'b1);
      acc(`TIMER_B_CONTROL_ADDR, 1'b0, 8'h00, 1'b1);
      run(1'b0, 8'h80, 8'h00, 64);
      run(1'b0, 8'h80, 8'($urandom % 16), 64);
      run(1'b0, 8'h82, 8'($urandom % 6), 512);
      run(1'b1, 8'h81, 8'hFF, 16);
      run(1'b1, 8'h80, 8'h03, 16);
      run(1'b1, 8'h83, 8'($urandom % 4), 256);
      run(1'b1, 8'h84, 8'($urandom % 50), 8);
      run(1'b1, 8'h86, 8'h00, 8);
      test_done();
   end
endmodule
`default_nettype wire
